// ### design/olsi_pkg.sv
// Package for the operator lamp status indicator: register map, fields, timing.
// Assumes a 125 MHz system clock and a 32-bit AXI4-Lite register bus.
package olsi_pkg;

  // Register byte offsets
  localparam logic [7:0] OLSI_CTRL_OFS    = 8'h00;
  localparam logic [7:0] OLSI_STATE_OFS   = 8'h04;
  localparam logic [7:0] OLSI_EVENT_OFS   = 8'h08;
  localparam logic [7:0] OLSI_LAMP_OFS    = 8'h0C;
  localparam logic [7:0] OLSI_IRQ_STS_OFS = 8'h10;
  localparam logic [7:0] OLSI_IRQ_MSK_OFS = 8'h14;

  // Control register fields
  localparam int OLSI_CTRL_ACCEPT_BIT = 0;
  localparam int OLSI_CTRL_REQREV_BIT = 1;
  localparam logic [1:0] OLSI_CTRL_RESET = 2'h0;

  // Event / interrupt bit positions
  localparam int OLSI_EV_LOCAL_TERM   = 0;
  localparam int OLSI_EV_NOTDRV_TERM  = 1;
  localparam int OLSI_EV_PANEL_STOP   = 2;
  localparam int OLSI_EV_POWERUP_RUN  = 3;
  localparam int OLSI_EV_ALARM        = 4;
  localparam int OLSI_NUM_EV          = 5;

  // Flash timing in milliseconds and clock rate
  localparam int OLSI_CLK_HZ        = 125_000_000;
  localparam int OLSI_FLASH_MS      = 500;
  localparam int OLSI_QUICK_MS      = 125;
  localparam int OLSI_FLASH_CYCLES  = OLSI_CLK_HZ / 1000 * OLSI_FLASH_MS;
  localparam int OLSI_QUICK_CYCLES  = OLSI_CLK_HZ / 1000 * OLSI_QUICK_MS;

  // AXI response codes
  localparam logic [1:0] OLSI_RESP_OKAY   = 2'h0;
  localparam logic [1:0] OLSI_RESP_SLVERR = 2'h2;

  // Drive status inputs
  typedef struct packed {
    logic alarm;
    logic param_err;
    logic tune_fault;
    logic tuning;
    logic reverse;
    logic drive_mode;
    logic show_output_frequency_lamp;
    logic local_ctrl;
    logic running;
    logic decel;
    logic fast_stop;
    logic safety_off;
    logic run_cmd;
    logic term_run;
    logic freq_zero;
    logic stop_key;
    logic powerup_run_accept_setting;
  } olsi_drive_t;

  // Lamp outputs
  typedef struct packed {
    logic alarm_lamp;
    logic reverse_direction_lamp;
    logic drive_mode_lamp;
    logic output_frequency_lamp;
    logic local_remote_lamp;
    logic run_lamp;
  } olsi_lamps_t;

  // Run lamp pattern choice
  typedef enum logic [1:0] {OLSI_RUN_OFF, OLSI_RUN_ON, OLSI_RUN_FLASH, OLSI_RUN_QUICK} olsi_run_t;

endpackage

// ### design/olsi_top.sv
// Operator lamp status indicator: decodes drive state into panel lamps.
// Assumes synchronous drive status inputs and an AXI4-Lite master on clk_i.
//
// Decided for this implementation: the placing of the registers and the AXI4-Lite slave port.
`timescale 1ns/1ns
module olsi_top
  import olsi_pkg::*;
#(
  parameter int FLASH_CYCLES = olsi_pkg::OLSI_FLASH_CYCLES,
  parameter int QUICK_CYCLES = olsi_pkg::OLSI_QUICK_CYCLES
) (
  // Clock and reset
  input  wire logic                  clk_i,
  input  wire logic                  rst_b_i,
  // Drive state
  input  wire olsi_pkg::olsi_drive_t drive_i,
  // Lamps, direction and interrupt
  output olsi_pkg::olsi_lamps_t      lamps_o,
  output logic                       reverse_select_o,
  output logic                       irq_o,
  // AXI4-Lite write address
  input  wire logic                  s_axi_awvalid_i,
  output logic                       s_axi_awready_o,
  input  wire logic [7:0]            s_axi_awaddr_i,
  // AXI4-Lite write data
  input  wire logic                  s_axi_wvalid_i,
  output logic                       s_axi_wready_o,
  input  wire logic [31:0]           s_axi_wdata_i,
  input  wire logic [3:0]            s_axi_wstrb_i,
  // AXI4-Lite write response
  output logic                       s_axi_bvalid_o,
  input  wire logic                  s_axi_bready_i,
  output logic [1:0]                 s_axi_bresp_o,
  // AXI4-Lite read address
  input  wire logic                  s_axi_arvalid_i,
  output logic                       s_axi_arready_o,
  input  wire logic [7:0]            s_axi_araddr_i,
  // AXI4-Lite read data
  output logic                       s_axi_rvalid_o,
  input  wire logic                  s_axi_rready_i,
  output logic [31:0]                s_axi_rdata_o,
  output logic [1:0]                 s_axi_rresp_o
);
  import olsi_pkg::*;

  // Flash dividers
  logic [31:0]         flash_cnt;
  logic [31:0]         quick_cnt;
  logic                flash_ph;
  logic                quick_ph;
  // Drive history
  olsi_drive_t         prev;
  logic                powered;
  logic                remote_hold;
  logic                notdrv_hold;
  logic                stop_hold;
  logic                powerup_hold;
  logic                alarm_flash;
  // Registers
  logic [1:0]          ctrl;
  logic [OLSI_NUM_EV-1:0] irq_sts;
  logic [OLSI_NUM_EV-1:0] irq_msk;
  logic                rev_sel;
  olsi_lamps_t         lamps;
  // Bus state
  logic                aw_held;
  logic                w_held;
  logic [7:0]          aw_addr;
  logic [31:0]         w_data;
  logic [3:0]          w_strb;
  logic                ack_alarm;

  wire flash_wrap = (flash_cnt == 32'(FLASH_CYCLES - 1));
  wire quick_wrap = (quick_cnt == 32'(QUICK_CYCLES - 1));

  always_ff @(posedge clk_i or negedge rst_b_i) begin
    if (!rst_b_i) begin
      flash_cnt <= 32'h0000_0000;
      quick_cnt <= 32'h0000_0000;
      flash_ph  <= 1'b0;
      quick_ph  <= 1'b0;
    end else begin
      flash_cnt <= flash_wrap ? 32'h0000_0000 : flash_cnt + 32'h0000_0001;
      quick_cnt <= quick_wrap ? 32'h0000_0000 : quick_cnt + 32'h0000_0001;
      flash_ph  <= flash_wrap ? ~flash_ph : flash_ph;
      quick_ph  <= quick_wrap ? ~quick_ph : quick_ph;
    end
  end

  // Edge terms of the drive inputs
  wire term_run_rise  = drive_i.term_run & ~prev.term_run;
  wire went_remote    = prev.local_ctrl & ~drive_i.local_ctrl;
  wire stop_press     = drive_i.stop_key & ~prev.stop_key;
  wire alarm_rise     = (drive_i.alarm & ~prev.alarm) | (drive_i.param_err & ~prev.param_err)
                        | (drive_i.tune_fault & ~prev.tune_fault);
  // terminal run entered in local, then switched remote
  wire ev_local_term  = went_remote & drive_i.term_run;
  wire ev_notdrv_term = term_run_rise & ~drive_i.drive_mode;
  wire ev_panel_stop  = stop_press & drive_i.running & ~drive_i.local_ctrl;
  // power-up with run active and setting zero
  wire ev_powerup     = ~powered & drive_i.run_cmd & ~drive_i.powerup_run_accept_setting;
  wire [OLSI_NUM_EV-1:0] events = {alarm_rise, ev_powerup, ev_panel_stop, ev_notdrv_term, ev_local_term};

  // Quick-flash holds: local terminal until term_run drops, not-drive terminal until term_run drops or drive_mode sets, stop and power-up until run_cmd drops
  always_ff @(posedge clk_i or negedge rst_b_i) begin
    if (!rst_b_i) begin
      prev         <= '0;
      powered      <= 1'b0;
      remote_hold  <= 1'b0;
      notdrv_hold  <= 1'b0;
      stop_hold    <= 1'b0;
      powerup_hold <= 1'b0;
      alarm_flash  <= 1'b0;
    end else begin
      prev         <= drive_i;
      powered      <= 1'b1;
      remote_hold  <= ev_local_term | (remote_hold & drive_i.term_run);
      notdrv_hold  <= ev_notdrv_term | (notdrv_hold & drive_i.term_run & ~drive_i.drive_mode);
      stop_hold    <= ev_panel_stop | (stop_hold & drive_i.run_cmd);
      powerup_hold <= ev_powerup | (powerup_hold & drive_i.run_cmd);
      // flash on a fresh alarm until acknowledged
      alarm_flash  <= alarm_rise | (alarm_flash & ~ack_alarm & (drive_i.alarm | drive_i.param_err
                      | drive_i.tune_fault));
    end
  end

  wire quick_any = remote_hold | notdrv_hold | stop_hold | powerup_hold
                   | (drive_i.fast_stop & drive_i.decel)
                   | drive_i.safety_off;
  wire flash_any = drive_i.decel | (drive_i.run_cmd & drive_i.freq_zero);
  olsi_run_t run_mode;
  assign run_mode = quick_any ? OLSI_RUN_QUICK :
                    flash_any ? OLSI_RUN_FLASH :
                    drive_i.running ? OLSI_RUN_ON : OLSI_RUN_OFF;

  logic run_lamp_n;
  always_comb begin
    case (run_mode)
      OLSI_RUN_QUICK: run_lamp_n = quick_ph;
      OLSI_RUN_FLASH: run_lamp_n = flash_ph;
      OLSI_RUN_ON:    run_lamp_n = 1'b1;
      default:        run_lamp_n = 1'b0;
    endcase
  end

  wire any_alarm   = drive_i.alarm | drive_i.param_err | drive_i.tune_fault;
  // Lamp goes dark as soon as every cause is gone, even in mid-flash
  wire alarm_lamp_n = any_alarm & (~alarm_flash | flash_ph);

  olsi_lamps_t next_lamps;
  always_comb begin
    next_lamps.alarm_lamp             = alarm_lamp_n;
    next_lamps.reverse_direction_lamp = drive_i.reverse;
    next_lamps.drive_mode_lamp        = drive_i.drive_mode | drive_i.tuning;
    next_lamps.output_frequency_lamp  = drive_i.show_output_frequency_lamp;
    next_lamps.local_remote_lamp      = drive_i.local_ctrl;
    next_lamps.run_lamp               = run_lamp_n;
  end

  always_ff @(posedge clk_i or negedge rst_b_i) begin
    if (!rst_b_i) begin
      lamps <= '0;
    end else begin
      lamps <= next_lamps;
    end
  end
  assign lamps_o = lamps;

  // AXI4-Lite write path: address and data taken in either order
  assign s_axi_awready_o = ~aw_held & ~s_axi_bvalid_o;
  assign s_axi_wready_o  = ~w_held & ~s_axi_bvalid_o;
  wire   aw_take   = s_axi_awvalid_i & s_axi_awready_o;
  wire   w_take    = s_axi_wvalid_i & s_axi_wready_o;
  wire   wr_fire   = aw_held & w_held;
  wire   wr_ctrl   = wr_fire & (aw_addr == OLSI_CTRL_OFS) & w_strb[0];
  wire   wr_sts    = wr_fire & (aw_addr == OLSI_IRQ_STS_OFS) & w_strb[0];
  wire   wr_msk    = wr_fire & (aw_addr == OLSI_IRQ_MSK_OFS) & w_strb[0];
  wire   wr_ok     = (aw_addr == OLSI_CTRL_OFS) | (aw_addr == OLSI_IRQ_STS_OFS)
                     | (aw_addr == OLSI_IRQ_MSK_OFS);
  assign ack_alarm = wr_sts & w_data[OLSI_EV_ALARM];
  wire [OLSI_NUM_EV-1:0] sts_clr = wr_sts ? w_data[OLSI_NUM_EV-1:0] : '0;

  // reverse only accepted under local control
  wire next_rev_sel = drive_i.local_ctrl ? ctrl[OLSI_CTRL_REQREV_BIT] : rev_sel;

  always_ff @(posedge clk_i or negedge rst_b_i) begin
    if (!rst_b_i) begin
      aw_held        <= 1'b0;
      w_held         <= 1'b0;
      aw_addr        <= 8'h00;
      w_data         <= 32'h0000_0000;
      w_strb         <= 4'h0;
      s_axi_bvalid_o <= 1'b0;
      s_axi_bresp_o  <= OLSI_RESP_OKAY;
      ctrl           <= OLSI_CTRL_RESET;
      irq_msk        <= '0;
      irq_sts        <= '0;
      rev_sel        <= 1'b0;
    end else begin
      if (aw_take) begin
        aw_held <= 1'b1;
        aw_addr <= {s_axi_awaddr_i[7:2], 2'b00};
      end else if (wr_fire) begin
        aw_held <= 1'b0;
      end
      if (w_take) begin
        w_held <= 1'b1;
        w_data <= s_axi_wdata_i;
        w_strb <= s_axi_wstrb_i;
      end else if (wr_fire) begin
        w_held <= 1'b0;
      end
      if (wr_fire) begin
        s_axi_bvalid_o <= 1'b1;
        s_axi_bresp_o  <= wr_ok ? OLSI_RESP_OKAY : OLSI_RESP_SLVERR;
      end else if (s_axi_bready_i) begin
        s_axi_bvalid_o <= 1'b0;
      end
      if (wr_ctrl) begin
        ctrl <= w_data[1:0];
      end
      if (wr_msk) begin
        irq_msk <= w_data[OLSI_NUM_EV-1:0];
      end
      // Set wins over a simultaneous write-one clear
      irq_sts <= (irq_sts & ~sts_clr) | events;
      rev_sel <= next_rev_sel;
    end
  end

  assign reverse_select_o = rev_sel;
  assign irq_o            = |(irq_sts & irq_msk);

  // AXI4-Lite read path
  assign s_axi_arready_o = ~s_axi_rvalid_o;
  wire [7:0] ra = {s_axi_araddr_i[7:2], 2'b00};
  wire [31:0] state_word = {15'h0000, drive_i};
  logic [31:0] rd_val;
  logic        rd_ok;
  always_comb begin
    rd_ok = 1'b1;
    if (ra == OLSI_CTRL_OFS) begin
      rd_val = {30'h0000_0000, ctrl};
    end else if (ra == OLSI_STATE_OFS) begin
      rd_val = state_word;
    end else if (ra == OLSI_EVENT_OFS) begin
      rd_val = {26'h000_0000, rev_sel, 1'b0, remote_hold, notdrv_hold, stop_hold, powerup_hold};
    end else if (ra == OLSI_LAMP_OFS) begin
      rd_val = {24'h00_0000, run_mode, lamps};
    end else if (ra == OLSI_IRQ_STS_OFS) begin
      rd_val = {27'h000_0000, irq_sts};
    end else if (ra == OLSI_IRQ_MSK_OFS) begin
      rd_val = {27'h000_0000, irq_msk};
    end else begin
      rd_val = 32'h0000_0000;
      rd_ok  = 1'b0;
    end
  end

  always_ff @(posedge clk_i or negedge rst_b_i) begin
    if (!rst_b_i) begin
      s_axi_rvalid_o <= 1'b0;
      s_axi_rdata_o  <= 32'h0000_0000;
      s_axi_rresp_o  <= OLSI_RESP_OKAY;
    end else begin
      if (s_axi_arvalid_i & s_axi_arready_o) begin
        s_axi_rvalid_o <= 1'b1;
        s_axi_rdata_o  <= rd_val;
        s_axi_rresp_o  <= rd_ok ? OLSI_RESP_OKAY : OLSI_RESP_SLVERR;
      end else if (s_axi_rready_i) begin
        s_axi_rvalid_o <= 1'b0;
      end
    end
  end

endmodule

// ### test/olsi_sva.sv
// Checker for the lamp outputs of olsi_top.
// Assumes it is bound onto olsi_top; lamps lag drive_i by one cycle.
`timescale 1ns/1ns
module olsi_sva
  import olsi_pkg::*;
#(
  parameter int FLASH_CYCLES = 16,
  parameter int QUICK_CYCLES = 4
) (
  // Watched ports
  input wire logic                  clk_i,
  input wire logic                  rst_b_i,
  input wire olsi_pkg::olsi_drive_t drive_i,
  input wire olsi_pkg::olsi_lamps_t lamps_o,
  input wire logic                  reverse_select_o
);
  default clocking cb @(posedge clk_i); endclocking
  default disable iff (!rst_b_i);
  wire         busy  = |{drive_i.decel, drive_i.run_cmd, drive_i.term_run, drive_i.fast_stop,
                         drive_i.safety_off, drive_i.stop_key};
  wire         quiet = !busy && !drive_i.running;
  wire         alone = !busy && drive_i.running;
  logic [31:0] stay;
  // Run length of the lamp while the safety stop holds; a slow pattern overruns it
  always_ff @(posedge clk_i or negedge rst_b_i) begin
    if (!rst_b_i) stay <= '0;
    else if (!drive_i.safety_off || $changed(lamps_o.run_lamp)) stay <= '0;
    else stay <= stay + 32'h0000_0001;
  end
  a_alarm_off: assert property (
    !(drive_i.alarm | drive_i.param_err | drive_i.tune_fault) |=> !lamps_o.alarm_lamp)
    else $error("alarm lamp lit without a cause");
  a_reverse_lamp: assert property (
    1 |=> lamps_o.reverse_direction_lamp == $past(drive_i.reverse))
    else $error("reverse lamp wrong");
  a_drive_lamp_on: assert property (
    drive_i.drive_mode || drive_i.tuning |=> lamps_o.drive_mode_lamp)
    else $error("drive mode lamp off");
  a_drive_lamp_off: assert property (
    !drive_i.drive_mode && !drive_i.tuning |=> !lamps_o.drive_mode_lamp)
    else $error("drive mode lamp lit");
  a_output_frequency_lamp_lamp: assert property (
    1 |=> lamps_o.output_frequency_lamp == $past(drive_i.show_output_frequency_lamp))
    else $error("frequency lamp wrong");
  a_local_lamp: assert property (
    1 |=> lamps_o.local_remote_lamp == $past(drive_i.local_ctrl))
    else $error("local lamp wrong");
  a_run_idle_off: assert property (
    quiet ##1 quiet |=> !lamps_o.run_lamp)
    else $error("run lamp lit when idle");
  a_run_steady_on: assert property (
    alone ##1 alone |=> lamps_o.run_lamp)
    else $error("run lamp not steady");
  a_quick_rate: assert property (
    stay <= QUICK_CYCLES + 1)
    else $error("quick flash too slow");
  a_reverse_local: assert property (
    $rose(reverse_select_o) |-> $past(drive_i.local_ctrl))
    else $error("reverse taken in remote");
  c_quick: cover property (drive_i.safety_off ##1 lamps_o.run_lamp);
  c_alarm: cover property ($rose(lamps_o.alarm_lamp));
  c_reverse: cover property ($rose(reverse_select_o));
endmodule
bind olsi_top olsi_sva #(.FLASH_CYCLES(FLASH_CYCLES), .QUICK_CYCLES(QUICK_CYCLES)) olsi_sva_inst (
  .clk_i(clk_i), .rst_b_i(rst_b_i), .drive_i(drive_i), .lamps_o(lamps_o),
  .reverse_select_o(reverse_select_o));

// ### test/olsi_drive_model.sv
// Drive-side model: presents the drive state levels to the lamp block.
// Assumes the bench posts a state; no reset, so levels survive a device reset.
`timescale 1ns/1ns
module olsi_drive_model
  import olsi_pkg::*;
(
  // Clock and requested state
  input  wire logic                  clk_i,
  input  wire olsi_pkg::olsi_drive_t req_i,
  // Levels seen by the device
  output olsi_pkg::olsi_drive_t      drive_o
);
  always @(posedge clk_i) begin
    drive_o <= req_i;
  end
endmodule

// ### test/olsi_top_bench.sv
// Self-checking bench for olsi_top with a drive model and AXI4-Lite tasks.
// Assumes short flash counts so that whole patterns fit in the run.
`timescale 1ns/1ns
`define CHK(g, e) begin n_tests++; if ((g) !== (e)) begin fail_count++; \
  $display("wrong value at %0t: got %h expected %h", $time, g, e); end end
module olsi_top_bench;
  import olsi_pkg::*;
  localparam int FL = 16;
  localparam int QK = 4;
  logic        clk_i = 0, rst_b_i = 0;
  olsi_drive_t req = '0, drv;
  olsi_lamps_t lamps;
  logic        rsel, irq, awv = 0, awr, wv = 0, wr, bv, br = 0, arv = 0, arr, rv, rr = 0;
  logic [7:0]  awa = '0, ara = '0;
  logic [31:0] wd = '0, rdat, q;
  logic [1:0]  bresp, rresp, resp;
  int          fail_count = 0, n_tests = 0;
  always #4 clk_i = ~clk_i;
  olsi_drive_model olsi_drive_model_inst (.clk_i(clk_i), .req_i(req), .drive_o(drv));
  olsi_top #(.FLASH_CYCLES(FL), .QUICK_CYCLES(QK)) olsi_top_inst (
    .clk_i(clk_i), .rst_b_i(rst_b_i), .drive_i(drv), .lamps_o(lamps), .reverse_select_o(rsel),
    .irq_o(irq), .s_axi_awvalid_i(awv), .s_axi_awready_o(awr), .s_axi_awaddr_i(awa),
    .s_axi_wvalid_i(wv), .s_axi_wready_o(wr), .s_axi_wdata_i(wd), .s_axi_wstrb_i(4'hF),
    .s_axi_bvalid_o(bv), .s_axi_bready_i(br), .s_axi_bresp_o(bresp), .s_axi_arvalid_i(arv),
    .s_axi_arready_o(arr), .s_axi_araddr_i(ara), .s_axi_rvalid_o(rv), .s_axi_rready_i(rr),
    .s_axi_rdata_o(rdat), .s_axi_rresp_o(rresp));
  task automatic print_verdict;
    $display("comparisons %0d mismatches %0d", n_tests, fail_count);
    if (fail_count == 0 && n_tests > 0) $display("All tests passed");
    else $display("Some tests failed");
    $finish;
  endtask
  // Each bus task ends one edge after its response so a strobe is never set twice in a step
  task automatic axi_wr(input logic [7:0] a, input logic [31:0] d);
    int t = 0;
    awv <= 1; awa <= a; wv <= 1; wd <= d; br <= 1;
    do begin
      @(posedge clk_i);
      t++;
      if (awv && awr) awv <= 0;
      if (wv && wr) wv <= 0;
    end while (bv !== 1'b1 && t < 50);
    resp = bresp;
    br <= 0;
    if (t >= 50) fail_count++;
    @(posedge clk_i);
  endtask
  task automatic axi_rd(input logic [7:0] a);
    int t = 0;
    arv <= 1; ara <= a; rr <= 1;
    do begin
      @(posedge clk_i);
      t++;
      if (arv && arr) arv <= 0;
    end while (rv !== 1'b1 && t < 50);
    q = rdat;
    resp = rresp;
    rr <= 0;
    if (t >= 50) fail_count++;
    @(posedge clk_i);
  endtask
  // Model and lamp register each add one cycle
  task automatic put(input olsi_drive_t s);
    req <= s;
    repeat (4) @(posedge clk_i);
  endtask
  task automatic mode(input logic [1:0] m);
    axi_rd(OLSI_LAMP_OFS);
    `CHK(q[7:6], m)
  endtask
  function automatic olsi_lamps_t exp_lamps(input olsi_drive_t s);
    olsi_lamps_t l;
    l = '0;
    l.reverse_direction_lamp = s.reverse;
    l.drive_mode_lamp = s.drive_mode | s.tuning;
    l.output_frequency_lamp = s.show_output_frequency_lamp;
    l.local_remote_lamp = s.local_ctrl;
    l.run_lamp = s.running;
    return l;
  endfunction
  initial begin
    olsi_drive_t s;
    olsi_drive_t cs [5];
    logic [1:0]  cm [5];
    int          n;
    logic        prev;
    void'($urandom(32'hd4da_39a2));
    cs = '{17'h0_0B80, 17'h0_0A14, 17'h0_0AC0, 17'h0_0B20, 17'h0_0B00};
    cm = '{2'h2, 2'h2, 2'h3, 2'h3, 2'h1};
    repeat (8) @(posedge clk_i);
    rst_b_i <= 1;
    @(posedge clk_i);
    `CHK(lamps, 6'h00)
    axi_rd(8'hFC);
    `CHK({resp, q}, {OLSI_RESP_SLVERR, 32'h0000_0000})
    axi_wr(8'hFC, 32'h0000_0003);
    `CHK(resp, OLSI_RESP_SLVERR)
    $display("test reset done");
    for (int i = 0; i < 30; i++) begin
      s = '0;
      {s.reverse, s.drive_mode, s.tuning, s.show_output_frequency_lamp, s.local_ctrl, s.running} = 6'($urandom);
      put(s);
      `CHK(lamps, exp_lamps(s))
      mode({1'b0, s.running});
    end
    $display("test static lamps done");
    foreach (cs[k]) begin
      put(cs[k]);
      mode(cm[k]);
      put(17'h0_0A00);
    end
    put(cs[3]);
    n = 0;
    prev = lamps.run_lamp;
    repeat (4 * QK) begin
      @(posedge clk_i);
      n += (lamps.run_lamp != prev);
      prev = lamps.run_lamp;
    end
    `CHK(n >= 3, 1'b1)
    put(17'h0_0A00);
    $display("test run patterns done");
    put(17'h0_0A18);
    put(17'h0_0818);
    mode(2'h3);
    put(17'h0_0A00);
    put(17'h0_0910);
    put(17'h0_0912);
    put(17'h0_0910);
    mode(2'h3);
    put(17'h0_0A00);
    put(17'h0_0018);
    mode(2'h3);
    `CHK(irq, 1'b0)
    axi_wr(OLSI_IRQ_MSK_OFS, 32'h0000_0002);
    `CHK(resp, OLSI_RESP_OKAY)
    `CHK(irq, 1'b1)
    put(17'h0_0A00);
    axi_rd(OLSI_IRQ_STS_OFS);
    `CHK(q[4:0], 5'h07)
    axi_wr(OLSI_IRQ_STS_OFS, 32'h0000_001F);
    `CHK(irq, 1'b0)
    $display("test quick holds done");
    put(17'h1_0A00);
    n = 0;
    prev = lamps.alarm_lamp;
    repeat (2 * FL + 4) begin
      @(posedge clk_i);
      n += (lamps.alarm_lamp != prev);
      prev = lamps.alarm_lamp;
    end
    `CHK(n >= 2, 1'b1)
    axi_wr(OLSI_IRQ_STS_OFS, 32'h0000_0010);
    repeat (2) @(posedge clk_i);
    `CHK(lamps.alarm_lamp, 1'b1)
    put(17'h0_0A00);
    `CHK(lamps.alarm_lamp, 1'b0)
    $display("test alarm done");
    axi_wr(OLSI_CTRL_OFS, 32'h0000_0002);
    `CHK(rsel, 1'b1)
    put(17'h0_0800);
    axi_wr(OLSI_CTRL_OFS, 32'h0000_0000);
    `CHK(rsel, 1'b1)
    $display("test reverse select done");
    // Run command alone, so after release only the run lamp moves, in quick flash from the power-up event
    req <= 17'h0_0010;
    rst_b_i <= 0;
    repeat (8) @(posedge clk_i);
    rst_b_i <= 1;
    repeat (3) @(posedge clk_i);
    mode(2'h3);
    axi_rd(OLSI_IRQ_STS_OFS);
    `CHK(q[3], 1'b1)
    $display("test power up done");
    print_verdict;
  end
  initial begin
    repeat (20000) @(posedge clk_i);
    fail_count++;
    print_verdict;
  end
endmodule
